// ---- hdl/link_pm_ctrl.sv ----
// Design decisions made here: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/10ps
// What this block does
// - enter suspend after more than 3.0 ms of unbroken upstream idle
// - fully suspended within 10 ms of the idle start
// - any non-idle activity restarts idle timing, blocking suspend; idle keeps counting through the high-speed revert
// - attach pull-up stays on while suspended
// - high-speed idle of 3.0 ms: revert to full-speed by 3.125 ms
// - revert means termination off and D+ pull-up back on
// - sample line 100 to 875 us after reverting: J suspends, SE0 means reset
// - remember prior high-speed and return to it on resume without reset
// - suspended device resumes on any non-idle upstream signalling
// - device resume only when software enabled remote wakeup
// - remote wakeup waits for 5 ms of continuous idle
// - remote wakeup drives resume 1 to 15 ms, then tri-states
// - high-speed link returns to high-speed within two LS bits of K-to-SE0
// - idle timers start two LS bit times after K-to-SE0
// - full/low-speed SE0 longer than 2.5 us is taken as reset
module link_pm_ctrl #(
  parameter int TICK_CYCLES = link_pm_pkg::TICK_CYCLES,
  parameter int IDLE_SUSPEND_US = link_pm_pkg::IDLE_SUSPEND_US,
  parameter int SUSPEND_AT_US = link_pm_pkg::SUSPEND_DONE_US - link_pm_pkg::SUSPEND_SETTLE_US,
  parameter int HS_IDLE_US = link_pm_pkg::HS_IDLE_REVERT_US,
  parameter int SAMPLE_AT_US = link_pm_pkg::SAMPLE_MIN_US,
  parameter int WAKE_IDLE_US = link_pm_pkg::REMOTE_WAKE_IDLE_WAIT_US,
  parameter int WAKE_MIN_US = link_pm_pkg::UP_RESUME_MIN_US,
  parameter int WAKE_MAX_US = link_pm_pkg::UP_RESUME_MAX_US
) (
  // system
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite slave
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // line side
  input link_pm_pkg::line_t line_state,
  input wire logic hs_enter,
  output link_pm_pkg::link_ctrl_t link_out,
  output logic bus_reset,
  output logic hs_handshake_start
);
  typedef logic [link_pm_pkg::TIMER_W-1:0] us_t;
  typedef logic [link_pm_pkg::CYC_W-1:0] cyc_t;

  localparam cyc_t SE0_CYC = cyc_t'(link_pm_pkg::SE0_RESET_DETECT_CYCLES);
  localparam cyc_t RET_CYC = cyc_t'(link_pm_pkg::HS_RETURN_CYCLES);

  function automatic logic [31:0] apply_strb(input logic [31:0] old, input logic [31:0] val, input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = val[8*i +: 8];
      end
    end
    return res;
  endfunction : apply_strb

  link_pm_pkg::state_t state;
  link_pm_pkg::state_t next_state;
  link_pm_pkg::link_ctrl_t next_link;
  logic next_bus_reset;
  logic next_hs_start;
  cyc_t se0_cnt;
  cyc_t next_se0_cnt;
  cyc_t ret_cnt;
  cyc_t next_ret_cnt;
  us_t idle_us;
  us_t phase_us;
  us_t resume_len;
  logic line_idle;
  logic idle_clear;
  logic se0_hit;
  logic wake_start;
  logic resume_evt;

  logic aw_got, next_aw_got, w_got, next_w_got;
  logic [7:0] awaddr_q, next_awaddr;
  logic [31:0] wdata_q, next_wdata;
  logic [3:0] wstrb_q, next_wstrb;
  logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
  logic [1:0] next_bresp, next_rresp;
  logic [31:0] next_rdata;
  logic [31:0] ctrl, next_ctrl, resume_time, next_resume_time, status_word;
  logic reset_seen, next_reset_seen, resume_seen, next_resume_seen;
  logic wake_pending, next_wake_pending;

  // in high-speed the idle line is SE0, in full/low-speed it is J
  assign line_idle = link_out.hs_mode ? (line_state == link_pm_pkg::LINE_SE0) : (line_state == link_pm_pkg::LINE_J);
  assign se0_hit = !link_out.hs_mode && (line_state == link_pm_pkg::LINE_SE0) && (se0_cnt == SE0_CYC - 1'b1);
  // idle keeps counting across the revert so suspend stays timed from the idle start
  assign idle_clear = (!line_idle && state != link_pm_pkg::ST_HS_REVERT)
    || state == link_pm_pkg::ST_RESUME || state == link_pm_pkg::ST_HS_RETURN;
  assign wake_start = (state == link_pm_pkg::ST_SUSPENDED) && (next_state == link_pm_pkg::ST_WAKE_DRIVE);
  assign resume_evt = (next_state == link_pm_pkg::ST_RESUME) && (state != link_pm_pkg::ST_RESUME);
  assign resume_len = (resume_time[15:0] < us_t'(WAKE_MIN_US)) ? us_t'(WAKE_MIN_US)
    : (resume_time[15:0] > us_t'(WAKE_MAX_US)) ? us_t'(WAKE_MAX_US) : resume_time[15:0];

  link_interval_timer #(.W(link_pm_pkg::TIMER_W), .TICK_CYCLES(TICK_CYCLES)) u_idle_timer (
    .aclk(aclk),
    .aresetn(aresetn),
    .clear(idle_clear),
    .count(idle_us)
  );

  link_interval_timer #(.W(link_pm_pkg::TIMER_W), .TICK_CYCLES(TICK_CYCLES)) u_phase_timer (
    .aclk(aclk),
    .aresetn(aresetn),
    .clear(next_state != state),
    .count(phase_us)
  );

  always_comb begin
    next_state = state;
    next_link = link_out;
    next_bus_reset = 1'b0;
    next_hs_start = 1'b0;
    next_ret_cnt = '0;
    next_se0_cnt = '0;
    if (!link_out.hs_mode && line_state == link_pm_pkg::LINE_SE0) begin
      next_se0_cnt = (se0_cnt == SE0_CYC) ? se0_cnt : se0_cnt + 1'b1;
    end
    if (se0_hit && state != link_pm_pkg::ST_HS_REVERT && state != link_pm_pkg::ST_WAKE_DRIVE) begin
      // reset also wakes a suspended device and forgets high-speed
      next_bus_reset = 1'b1;
      next_state = link_pm_pkg::ST_ACTIVE;
      next_link.hs_remembered = 1'b0;
      next_link.suspended = 1'b0;
    end else begin
      case (state)
        link_pm_pkg::ST_ACTIVE: begin
          if (link_out.hs_mode && line_idle && idle_us >= us_t'(HS_IDLE_US)) begin
            next_link.hs_mode = 1'b0;
            next_link.hs_term_en = 1'b0;
            next_link.hs_remembered = 1'b1;
            next_state = link_pm_pkg::ST_HS_REVERT;
          end else if (!link_out.hs_mode && line_idle && idle_us > us_t'(IDLE_SUSPEND_US)) begin
            next_state = link_pm_pkg::ST_SUSPENDING;
          end else if (!link_out.hs_mode && hs_enter && !ctrl[link_pm_pkg::CTRL_LOW_SPEED_BIT]) begin
            next_link.hs_mode = 1'b1;
            next_link.hs_term_en = 1'b1;
          end
        end
        link_pm_pkg::ST_HS_REVERT: begin
          if (phase_us >= us_t'(SAMPLE_AT_US)) begin
            if (line_state == link_pm_pkg::LINE_J) begin
              next_state = link_pm_pkg::ST_SUSPENDING;
            end else if (line_state == link_pm_pkg::LINE_SE0) begin
              next_hs_start = 1'b1;
              next_link.hs_remembered = 1'b0;
              next_state = link_pm_pkg::ST_ACTIVE;
            end else begin
              next_state = link_pm_pkg::ST_RESUME;
            end
          end
        end
        link_pm_pkg::ST_SUSPENDING: begin
          if (!line_idle) begin
            next_state = link_out.hs_remembered ? link_pm_pkg::ST_RESUME : link_pm_pkg::ST_ACTIVE;
          end else if (idle_us >= us_t'(SUSPEND_AT_US)) begin
            next_link.suspended = 1'b1;
            next_state = link_pm_pkg::ST_SUSPENDED;
          end
        end
        link_pm_pkg::ST_SUSPENDED: begin
          if (!line_idle) begin
            next_link.suspended = 1'b0;
            next_state = link_pm_pkg::ST_RESUME;
          end else if (wake_pending && ctrl[link_pm_pkg::CTRL_WAKE_EN_BIT]
              && idle_us >= us_t'(WAKE_IDLE_US)) begin
            next_link.suspended = 1'b0;
            next_link.drive_k = 1'b1;
            next_link.tx_oe_n = 1'b0;
            next_state = link_pm_pkg::ST_WAKE_DRIVE;
          end
        end
        link_pm_pkg::ST_WAKE_DRIVE: begin
          if (phase_us >= resume_len) begin
            // release rather than drive J; the host carries resume on
            next_link.drive_k = 1'b0;
            next_link.tx_oe_n = 1'b1;
            next_state = link_pm_pkg::ST_RESUME;
          end
        end
        link_pm_pkg::ST_RESUME: begin
          if (line_state == link_pm_pkg::LINE_SE0) begin
            next_ret_cnt = cyc_t'(1);
            next_state = link_out.hs_remembered ? link_pm_pkg::ST_HS_RETURN : link_pm_pkg::ST_FS_EOP;
          end
        end
        link_pm_pkg::ST_HS_RETURN: begin
          next_ret_cnt = ret_cnt + 1'b1;
          if (ret_cnt == RET_CYC - 1'b1) begin
            next_link.hs_mode = 1'b1;
            next_link.hs_term_en = 1'b1;
            next_link.hs_remembered = 1'b0;
            next_state = link_pm_pkg::ST_ACTIVE;
          end
        end
        link_pm_pkg::ST_FS_EOP: begin
          if (line_state == link_pm_pkg::LINE_J) begin
            next_state = link_pm_pkg::ST_ACTIVE;
          end
        end
        default: begin
          next_state = link_pm_pkg::ST_ACTIVE;
        end
      endcase
    end
    if (next_bus_reset) begin
      next_link.hs_mode = 1'b0;
      next_link.hs_term_en = 1'b0;
    end
    // attach pull-up follows speed only, so suspend never drops it
    next_link.pullup_dm_en = ctrl[link_pm_pkg::CTRL_LOW_SPEED_BIT];
    next_link.pullup_dp_en = !ctrl[link_pm_pkg::CTRL_LOW_SPEED_BIT] && !next_link.hs_term_en;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= link_pm_pkg::ST_ACTIVE;
      link_out <= link_pm_pkg::LINK_RESET;
      bus_reset <= 1'b0;
      hs_handshake_start <= 1'b0;
      se0_cnt <= '0;
      ret_cnt <= '0;
    end else begin
      state <= next_state;
      link_out <= next_link;
      bus_reset <= next_bus_reset;
      hs_handshake_start <= next_hs_start;
      se0_cnt <= next_se0_cnt;
      ret_cnt <= next_ret_cnt;
    end
  end

  assign status_word = {14'h0000, resume_seen, reset_seen, 5'h00, link_out.suspended,
    link_out.hs_remembered, link_out.hs_mode, state};

  // write channel: address and data taken in either order, answered one cycle after both
  always_comb begin
    next_aw_got = aw_got;
    next_awaddr = awaddr_q;
    next_w_got = w_got;
    next_wdata = wdata_q;
    next_wstrb = wstrb_q;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_ctrl = ctrl;
    next_resume_time = resume_time;
    next_reset_seen = reset_seen | bus_reset;
    next_resume_seen = resume_seen | resume_evt;
    next_wake_pending = wake_pending && !wake_start;
    if (awvalid && awready) begin
      next_aw_got = 1'b1;
      next_awaddr = awaddr;
    end
    if (wvalid && wready) begin
      next_w_got = 1'b1;
      next_wdata = wdata;
      next_wstrb = wstrb;
    end
    if (bvalid && bready) begin
      next_bvalid = 1'b0;
    end
    if (next_aw_got && next_w_got && !bvalid) begin
      next_aw_got = 1'b0;
      next_w_got = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = link_pm_pkg::RESP_OKAY;
      case (next_awaddr)
        link_pm_pkg::REG_CTRL: begin
          next_ctrl = apply_strb(ctrl, next_wdata, next_wstrb) & link_pm_pkg::CTRL_MASK;
          if (next_wstrb[0] && next_wdata[link_pm_pkg::CTRL_WAKE_REQ_BIT]) begin
            next_wake_pending = 1'b1;
          end
        end
        link_pm_pkg::REG_RESUME_TIME: begin
          next_resume_time = apply_strb(resume_time, next_wdata, next_wstrb);
        end
        link_pm_pkg::REG_STATUS: begin
          // write-one-to-clear; a new event in the same cycle stays set
          if (next_wstrb[2] && next_wdata[link_pm_pkg::STAT_RESET_SEEN_BIT]) begin
            next_reset_seen = bus_reset;
          end
          if (next_wstrb[2] && next_wdata[link_pm_pkg::STAT_RESUME_SEEN_BIT]) begin
            next_resume_seen = resume_evt;
          end
        end
        link_pm_pkg::REG_IDLE_TIME: begin
        end
        default: begin
          next_bresp = link_pm_pkg::RESP_SLVERR;
        end
      endcase
    end
    if (!next_ctrl[link_pm_pkg::CTRL_WAKE_EN_BIT]) begin
      next_wake_pending = 1'b0;
    end
    next_awready = !next_aw_got && !next_bvalid;
    next_wready = !next_w_got && !next_bvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got <= 1'b0;
      awaddr_q <= 8'h00;
      w_got <= 1'b0;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= link_pm_pkg::RESP_OKAY;
      ctrl <= link_pm_pkg::CTRL_RESET;
      resume_time <= link_pm_pkg::RESUME_TIME_RESET;
      reset_seen <= 1'b0;
      resume_seen <= 1'b0;
      wake_pending <= 1'b0;
    end else begin
      aw_got <= next_aw_got;
      awaddr_q <= next_awaddr;
      w_got <= next_w_got;
      wdata_q <= next_wdata;
      wstrb_q <= next_wstrb;
      awready <= next_awready;
      wready <= next_wready;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      ctrl <= next_ctrl;
      resume_time <= next_resume_time;
      reset_seen <= next_reset_seen;
      resume_seen <= next_resume_seen;
      wake_pending <= next_wake_pending;
    end
  end

  // read channel
  always_comb begin
    next_rvalid = rvalid;
    next_rdata = rdata;
    next_rresp = rresp;
    if (rvalid && rready) begin
      next_rvalid = 1'b0;
    end
    if (arvalid && arready) begin
      next_rvalid = 1'b1;
      next_rresp = link_pm_pkg::RESP_OKAY;
      case (araddr)
        link_pm_pkg::REG_CTRL: next_rdata = ctrl;
        link_pm_pkg::REG_RESUME_TIME: next_rdata = resume_time;
        link_pm_pkg::REG_STATUS: next_rdata = status_word;
        link_pm_pkg::REG_IDLE_TIME: next_rdata = {16'h0000, idle_us};
        default: begin
          next_rdata = 32'h00000000;
          next_rresp = link_pm_pkg::RESP_SLVERR;
        end
      endcase
    end
    next_arready = !next_rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= link_pm_pkg::RESP_OKAY;
    end else begin
      arready <= next_arready;
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
    end
  end

  chk_idle_entry: assert property (@(posedge aclk) disable iff (!aresetn)
    (state == link_pm_pkg::ST_ACTIVE && !link_out.hs_mode && line_idle && !se0_hit
      && idle_us > us_t'(IDLE_SUSPEND_US)) |=> (state == link_pm_pkg::ST_SUSPENDING))
    else $error("idle past limit did not start suspend");
  chk_suspend_deadline: assert property (@(posedge aclk) disable iff (!aresetn)
    (state == link_pm_pkg::ST_SUSPENDING && line_idle && idle_us >= us_t'(SUSPEND_AT_US))
      |=> (link_out.suspended && idle_us <= us_t'(link_pm_pkg::SUSPEND_DONE_US)))
    else $error("suspend not reached in time");
  chk_activity_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    (!line_idle && state == link_pm_pkg::ST_ACTIVE) |=> (idle_us == '0))
    else $error("activity did not restart idle timing");
  chk_pullup_kept: assert property (@(posedge aclk) disable iff (!aresetn)
    link_out.suspended |-> (link_out.pullup_dp_en ^ link_out.pullup_dm_en))
    else $error("pull-up lost in suspend");
  chk_revert_time: assert property (@(posedge aclk) disable iff (!aresetn)
    ($fell(link_out.hs_term_en) && state == link_pm_pkg::ST_HS_REVERT) |-> (link_out.pullup_dp_en
      && link_out.hs_remembered && $past(idle_us) <= us_t'(link_pm_pkg::HS_REVERT_DEADLINE_US)))
    else $error("bad high-speed reversion");
  chk_sample_window: assert property (@(posedge aclk) disable iff (!aresetn)
    (state == link_pm_pkg::ST_HS_REVERT && next_state != link_pm_pkg::ST_HS_REVERT)
      |-> (phase_us >= us_t'(link_pm_pkg::SAMPLE_MIN_US) && phase_us <= us_t'(link_pm_pkg::SAMPLE_MAX_US)))
    else $error("line sampled outside window");
  chk_wake_gate: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(link_out.drive_k) |-> ($past(ctrl[link_pm_pkg::CTRL_WAKE_EN_BIT])
      && $past(idle_us) >= us_t'(WAKE_IDLE_US) && !link_out.tx_oe_n))
    else $error("remote wakeup started without permission");
  chk_wake_release: assert property (@(posedge aclk) disable iff (!aresetn)
    $fell(link_out.drive_k) |-> (link_out.tx_oe_n && $past(phase_us) >= us_t'(WAKE_MIN_US)
      && $past(phase_us) <= us_t'(WAKE_MAX_US)))
    else $error("remote wakeup length wrong");
  chk_hs_return: assert property (@(posedge aclk) disable iff (!aresetn)
    (state == link_pm_pkg::ST_RESUME && link_out.hs_remembered && line_state == link_pm_pkg::LINE_SE0)
      |-> ##[1:13] (link_out.hs_term_en && idle_us == '0))
    else $error("no high-speed return after resume");
  chk_se0_reset: assert property (@(posedge aclk) disable iff (!aresetn)
    (se0_hit && state == link_pm_pkg::ST_ACTIVE) |=> (bus_reset && !link_out.hs_remembered))
    else $error("long SE0 not taken as reset");
endmodule : link_pm_ctrl

// ---- hdl/link_pm_pkg.sv ----
package link_pm_pkg;
  // clock and base units
  localparam int CLK_PERIOD_NS = 100;
  localparam int NS_PER_US = 1000;
  localparam int TICK_CYCLES = NS_PER_US / CLK_PERIOD_NS;
  localparam int TIMER_W = 16;
  localparam int CYC_W = 8;

  // link timing, microseconds
  localparam int IDLE_SUSPEND_US = 3000;
  localparam int SUSPEND_DONE_US = 10000;
  localparam int SUSPEND_SETTLE_US = 1000;
  localparam int HS_IDLE_REVERT_US = 3000;
  localparam int HS_REVERT_DEADLINE_US = 3125;
  localparam int SAMPLE_MIN_US = 100;
  localparam int SAMPLE_MAX_US = 875;
  localparam int REMOTE_WAKE_IDLE_WAIT_US = 5000;
  localparam int UP_RESUME_MIN_US = 1000;
  localparam int UP_RESUME_MAX_US = 15000;

  // short line timing in clock cycles
  localparam int SE0_RESET_DETECT_NS = 2500;
  localparam int SE0_RESET_DETECT_CYCLES = (SE0_RESET_DETECT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LS_BIT_RATE_KBPS = 1500;
  localparam int NS_PER_MS = 1000000;
  localparam int TWO_LS_BITS_NS = 2 * NS_PER_MS / LS_BIT_RATE_KBPS;
  localparam int HS_RETURN_CYCLES = TWO_LS_BITS_NS / CLK_PERIOD_NS;

  // sampled line state
  typedef enum logic [1:0] {
    LINE_SE0 = 2'h0,
    LINE_J = 2'h1,
    LINE_K = 2'h2,
    LINE_SE1 = 2'h3
  } line_t;

  typedef enum logic [7:0] {
    ST_ACTIVE = 8'h01,
    ST_HS_REVERT = 8'h02,
    ST_SUSPENDING = 8'h04,
    ST_SUSPENDED = 8'h08,
    ST_WAKE_DRIVE = 8'h10,
    ST_RESUME = 8'h20,
    ST_HS_RETURN = 8'h40,
    ST_FS_EOP = 8'h80
  } state_t;

  // transceiver controls and link status, all registered
  typedef struct packed {
    logic hs_term_en;
    logic pullup_dp_en;
    logic pullup_dm_en;
    logic drive_k;
    logic tx_oe_n;
    logic hs_mode;
    logic suspended;
    logic hs_remembered;
  } link_ctrl_t;

  localparam link_ctrl_t LINK_RESET = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0};

  // register map
  localparam int ADDR_W = 8;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_RESUME_TIME = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_IDLE_TIME = 8'h0C;
  localparam int CTRL_WAKE_EN_BIT = 0;
  localparam int CTRL_LOW_SPEED_BIT = 1;
  localparam int CTRL_WAKE_REQ_BIT = 2;
  localparam logic [31:0] CTRL_MASK = 32'h00000003;
  localparam logic [31:0] CTRL_RESET = 32'h00000000;
  localparam logic [31:0] RESUME_TIME_RESET = 32'h000007D0;
  localparam int STAT_HS_MODE_BIT = 8;
  localparam int STAT_HS_MEM_BIT = 9;
  localparam int STAT_SUSP_BIT = 10;
  localparam int STAT_RESET_SEEN_BIT = 16;
  localparam int STAT_RESUME_SEEN_BIT = 17;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : link_pm_pkg

// ---- hdl/link_interval_timer.sv ----
`timescale 1ns/10ps
module link_interval_timer #(
  parameter int W = 16,
  parameter int TICK_CYCLES = 10
) (
  // system
  input wire logic aclk,
  input wire logic aresetn,
  // restart the interval
  input wire logic clear,
  // elapsed microseconds, saturating
  output logic [W-1:0] count
);
  logic [7:0] div;
  logic [7:0] next_div;
  logic [W-1:0] next_count;

  // divider restarts with the count so intervals start on a clean tick boundary
  always_comb begin
    next_div = div;
    next_count = count;
    if (clear) begin
      next_div = 8'h00;
      next_count = '0;
    end else if (div == 8'(TICK_CYCLES - 1)) begin
      next_div = 8'h00;
      if (count != '1) begin
        next_count = count + 1'b1;
      end
    end else begin
      next_div = div + 8'h01;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div <= 8'h00;
      count <= '0;
    end else begin
      div <= next_div;
      count <= next_count;
    end
  end
endmodule : link_interval_timer

// ---- tb/host_port_model.sv ----
`timescale 1ns/10ps
module host_port_model (
  // system
  input wire logic aclk,
  // scenario control and device drive
  input wire logic [1:0] mode,
  input link_pm_pkg::link_ctrl_t link_out,
  // resolved line
  output link_pm_pkg::line_t line_state
);
  logic [4:0] tick = 5'h00;
  always_ff @(posedge aclk) begin
    tick <= tick + 5'h01;
  end
  // enabled device drivers win over the host side
  always_comb begin
    if (!link_out.tx_oe_n) line_state = link_out.drive_k ? link_pm_pkg::LINE_K : link_pm_pkg::LINE_J;
    else if (mode == 2'h1) line_state = (tick == 5'h00) ? link_pm_pkg::LINE_K : link_pm_pkg::LINE_J;
    // resume from the far end, whether host, relaying hub or controlling hub
    else if (mode == 2'h2) line_state = link_pm_pkg::LINE_K;
    // high-speed resume end holds SE0 with no J step
    else if (mode == 2'h3) line_state = link_pm_pkg::LINE_SE0;
    // far end sits in full-speed idle and never wakes unasked
    else line_state = link_pm_pkg::LINE_J;
  end
endmodule : host_port_model

// ---- tb/tb.sv ----
`timescale 1ns/10ps
module tb;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, ev;
  logic [31:0] wdata = 32'h00000000, rdata, rd_val;
  logic [3:0] wstrb = 4'hF;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0, hs_enter = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, bus_reset, hs_handshake_start;
  logic [1:0] bresp, rresp, mode = 2'h0;
  link_pm_pkg::line_t line_state;
  link_pm_pkg::link_ctrl_t link_out;
  int error_cnt = 0, num_checks = 0, n;
  assign ev = {hs_handshake_start, bus_reset, link_out.hs_term_en, link_out.tx_oe_n, ~link_out.tx_oe_n,
    ~link_out.suspended, link_out.suspended, link_out.hs_remembered};
  always #50 aclk = ~aclk;
  link_pm_ctrl #(.TICK_CYCLES(1), .IDLE_SUSPEND_US(30), .SUSPEND_AT_US(90), .HS_IDLE_US(30),
    .WAKE_IDLE_US(50)) i_link_pm_ctrl (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .line_state, .hs_enter, .link_out, .bus_reset, .hs_handshake_start);
  host_port_model i_host_port_model (.aclk, .mode, .link_out, .line_state);
  task end_of_test;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_of_test
  task chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
      error_cnt++;
    end
  endtask : chk
  task rng(input int lo, input int hi);
    chk(32'(n >= lo && n <= hi), 32'h1);
  endtask : rng
  // responses sampled mid-cycle, so drives land only after the edge
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw, w, b;
    int k;
    @(posedge aclk);
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    b = 1'b0;
    for (k = 0; k < 40 && !b; k++) begin
      @(negedge aclk);
      aw = awready; w = wready; b = (bvalid === 1'b1); rd_val = 32'(bresp);
      @(posedge aclk);
      if (aw === 1'b1) awvalid <= 1'b0;
      if (w === 1'b1) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    chk(rd_val, 32'(er));
    chk(32'(b), 32'h1);
    if (!b) end_of_test;
  endtask : wr
  task rd(input logic [7:0] a, input logic [1:0] er);
    logic ar, r;
    logic [1:0] rs;
    int k;
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    r = 1'b0;
    for (k = 0; k < 40 && !r; k++) begin
      @(negedge aclk);
      ar = arready; r = (rvalid === 1'b1); rd_val = rdata; rs = rresp;
      @(posedge aclk);
      if (ar === 1'b1) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    chk(32'(rs), 32'(er));
    chk(32'(r), 32'h1);
    if (!r) end_of_test;
  endtask : rd
  task md(input logic [1:0] m);
    @(posedge aclk);
    mode <= m;
  endtask : md
  task wt(input int s, input int lim);
    n = 0;
    do begin
      @(negedge aclk);
      n++;
    end while (ev[s] !== 1'b1 && n < lim);
    chk(32'(ev[s]), 32'h1);
    if (ev[s] !== 1'b1) end_of_test;
  endtask : wt
  task s_regs;
    rd(link_pm_pkg::REG_CTRL, link_pm_pkg::RESP_OKAY);
    chk(rd_val, link_pm_pkg::CTRL_RESET);
    rd(link_pm_pkg::REG_RESUME_TIME, link_pm_pkg::RESP_OKAY);
    chk(rd_val, link_pm_pkg::RESUME_TIME_RESET);
    wr(8'h10, 32'hFFFFFFFF, link_pm_pkg::RESP_SLVERR);
    rd(8'h10, link_pm_pkg::RESP_SLVERR);
    chk(rd_val, 32'h00000000);
    wr(link_pm_pkg::REG_RESUME_TIME, 32'h00000000, link_pm_pkg::RESP_OKAY);
    rd(link_pm_pkg::REG_RESUME_TIME, link_pm_pkg::RESP_OKAY);
    // stored as written; the clamp acts only on the drive length
    chk(rd_val, 32'h00000000);
  endtask : s_regs
  task s_susp;
    md(2'h1);
    repeat (200) @(posedge aclk);
    chk(32'(link_out.suspended), 32'h0);
    md(2'h0);
    wt(1, 120);
    rng(31, 100);
    chk(32'(link_out.pullup_dp_en), 32'h1);
    chk(32'(link_out.pullup_dm_en), 32'h0);
    rd(link_pm_pkg::REG_IDLE_TIME, link_pm_pkg::RESP_OKAY);
    n = rd_val;
    rng(91, 100);
    md(2'h2);
    wt(2, 20);
    repeat (200) @(posedge aclk);
    md(2'h3);
    repeat (13) @(posedge aclk);
    md(2'h0);
    rd(link_pm_pkg::REG_STATUS, link_pm_pkg::RESP_OKAY);
    chk(32'(rd_val[7:0]), 32'(link_pm_pkg::ST_ACTIVE));
    chk(32'(rd_val[17:8]), 32'h00000200);
    md(2'h3);
    wt(6, 40);
    rng(25, 28);
    md(2'h1);
  endtask : s_susp
  task s_wake;
    rd(link_pm_pkg::REG_STATUS, link_pm_pkg::RESP_OKAY);
    chk(32'(rd_val[17:16]), 32'h3);
    wr(link_pm_pkg::REG_STATUS, 32'h00030000, link_pm_pkg::RESP_OKAY);
    rd(link_pm_pkg::REG_STATUS, link_pm_pkg::RESP_OKAY);
    chk(32'(rd_val[17:16]), 32'h0);
    wr(link_pm_pkg::REG_CTRL, 32'h00000004, link_pm_pkg::RESP_OKAY);
    md(2'h0);
    n = 0;
    repeat (150) @(negedge aclk) if (ev[3] !== 1'b0) n++;
    chk(32'(n), 32'h0);
    md(2'h2);
    wt(2, 20);
    wr(link_pm_pkg::REG_CTRL, 32'h00000005, link_pm_pkg::RESP_OKAY);
    md(2'h3);
    repeat (13) @(posedge aclk);
    md(2'h0);
    // wake only from suspend, reached at 90 idle, well past the 50 idle wait
    wt(3, 120);
    rng(91, 95);
    chk(32'(link_out.drive_k), 32'h1);
    md(2'h2);
    wt(4, 1100);
    rng(998, 1002);
    repeat (200) @(posedge aclk);
    md(2'h3);
    repeat (13) @(posedge aclk);
    md(2'h1);
  endtask : s_wake
  task s_hs;
    // let the end-of-resume J bring the state back to active first
    repeat (3) @(posedge aclk);
    hs_enter <= 1'b1;
    @(posedge aclk) hs_enter <= 1'b0;
    md(2'h3);
    wt(0, 40);
    rng(30, 32);
    chk({30'h0, link_out.hs_term_en, link_out.pullup_dp_en}, 32'h1);
    md(2'h0);
    wt(1, 300);
    md(2'h2);
    repeat (200) @(posedge aclk);
    md(2'h3);
    wt(5, 20);
    rng(1, 15);
    chk(32'(link_out.pullup_dp_en), 32'h0);
    chk(32'(link_out.hs_mode), 32'h1);
    wt(7, 950);
    rng(130, 920);
  endtask : s_hs
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    s_regs;
    s_susp;
    s_wake;
    s_hs;
    end_of_test;
  end
endmodule : tb
